// ---- design/pcpa_crossbar.sv ----
`timescale 1ns/1ps
module pcpa_crossbar (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [7:0]             crossbar_select_a,
  input  wire logic [7:0]             crossbar_select_b,
  input  wire logic [7:0]             crossbar_select_c,
  input  wire logic [7:0]             pin_skip_mask_p0,
  input  wire logic [7:0]             pin_skip_mask_p1,
  input  wire logic [7:0]             pin_skip_mask_p2,
  input  wire logic [23:0]            output_mode_select,
  input  wire logic [23:0]            input_mode_select,
  input  wire logic [23:0]            drive_strength_select,
  input  wire logic [23:0]            port_latch,
  input  wire logic [1:0]             slave_select_mode_field,
  input  wire logic                   radio_link_four_wire,
  input  wire logic [pcpa_pkg::NSIG-1:0] sig_out,
  input  wire logic [pcpa_pkg::NSIG-1:0] sig_oe,
  input  wire logic [7:0]             ext_irq_pin_config,
  input  wire logic [7:0]             port_a_match_mask,
  input  wire logic [7:0]             port_a_match_value,
  input  wire logic [pcpa_pkg::NPIN-1:0] pad_in,
  output logic [pcpa_pkg::NPIN-1:0]   pad_out,
  output logic [pcpa_pkg::NPIN-1:0]   pad_oe_n,
  output logic [pcpa_pkg::NPIN-1:0]   pad_pullup_en,
  output logic [pcpa_pkg::NPIN-1:0]   pad_drive_high,
  output logic [pcpa_pkg::NPIN-1:0]   port_read,
  output logic [pcpa_pkg::NSIG-1:0]   sig_in,
  output logic [pcpa_pkg::NPIN-1:0]   pin_edge,
  output logic                        ext_irq0,
  output logic                        ext_irq1,
  output logic                        port_match,
  output logic                        alloc_overflow
);
  import pcpa_pkg::*;
  // configuration group
  logic [NPIN-1:0] skip_r, skip_nxt;
  logic [NPIN-1:0] inmode_r, inmode_nxt;
  logic [NPIN-1:0] outmode_r, outmode_nxt;
  logic [NPIN-1:0] drv_r, drv_nxt;
  logic [NPIN-1:0] latch_r, latch_nxt;
  logic [7:0]      sel_a_r, sel_a_nxt;
  logic [7:0]      sel_b_r, sel_b_nxt;
  logic            xbar_en_r, xbar_en_nxt;
  logic            gen_four_r, gen_four_nxt;
  logic            rad_four_r, rad_four_nxt;
  always_comb begin
    skip_nxt     = {pin_skip_mask_p2[6:0], pin_skip_mask_p1,
                    pin_skip_mask_p0};
    inmode_nxt   = input_mode_select[NPIN-1:0];
    outmode_nxt  = output_mode_select[NPIN-1:0];
    drv_nxt      = drive_strength_select[NPIN-1:0];
    latch_nxt    = port_latch[NPIN-1:0];
    sel_a_nxt    = crossbar_select_a;
    sel_b_nxt    = crossbar_select_b;
    xbar_en_nxt  = crossbar_select_c[SC_XBAR_EN];
    gen_four_nxt = slave_select_mode_field[SSM_FOUR];
    rad_four_nxt = radio_link_four_wire;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_r     <= {SKIP_RST[6:0], SKIP_RST, SKIP_RST};
      inmode_r   <= INMODE_RST[NPIN-1:0];
      outmode_r  <= OUTMODE_RST[NPIN-1:0];
      drv_r      <= DRV_RST[NPIN-1:0];
      latch_r    <= LATCH_RST[NPIN-1:0];
      {sel_a_r, sel_b_r} <= 16'h0000;
      {xbar_en_r, gen_four_r, rad_four_r} <= 3'b000;
    end else begin
      skip_r     <= skip_nxt;
      inmode_r   <= inmode_nxt;
      outmode_r  <= outmode_nxt;
      drv_r      <= drv_nxt;
      latch_r    <= latch_nxt;
      {sel_a_r, sel_b_r} <= {sel_a_nxt, sel_b_nxt};
      {xbar_en_r, gen_four_r, rad_four_r} <=
        {xbar_en_nxt, gen_four_nxt, rad_four_nxt};
    end
  end
  // per-signal enables
  logic [NSIG-1:0] sig_en;
  logic [2:0]      pca_cnt;
  always_comb begin
    pca_cnt = sel_b_r[SB_PCA_LSB +: 3];
    sig_en  = '0;
    sig_en[SIG_UART_TX]  = sel_a_r[SA_UART];
    sig_en[SIG_UART_RX]  = sel_a_r[SA_UART];
    sig_en[SIG_RAD_SCK]  = sel_b_r[SB_RADIO];
    sig_en[SIG_RAD_MISO] = sel_b_r[SB_RADIO];
    sig_en[SIG_RAD_MOSI] = sel_b_r[SB_RADIO];
    sig_en[SIG_RAD_NSS]  = sel_b_r[SB_RADIO] & rad_four_r;
    sig_en[SIG_GEN_SCK]  = sel_a_r[SA_GEN];
    sig_en[SIG_GEN_MISO] = sel_a_r[SA_GEN];
    sig_en[SIG_GEN_MOSI] = sel_a_r[SA_GEN];
    sig_en[SIG_GEN_NSS]  = sel_a_r[SA_GEN] & gen_four_r;
    sig_en[SIG_SDA]      = sel_a_r[SA_SMB];
    sig_en[SIG_SCL]      = sel_a_r[SA_SMB];
    sig_en[SIG_CP0]      = sel_a_r[SA_CP0];
    sig_en[SIG_CP0A]     = sel_a_r[SA_CP0A];
    sig_en[SIG_CP1]      = sel_a_r[SA_CP1];
    sig_en[SIG_CP1A]     = sel_a_r[SA_CP1A];
    sig_en[SIG_SYSCK]    = sel_a_r[SA_SYSCK];
    // codes above six are clamped to six channels
    for (int k = 0; k < PCA_MAX; k++) begin
      sig_en[int'(SIG_CEX0) + k] = k < int'(pca_cnt);
    end
    sig_en[SIG_ECI]      = sel_b_r[SB_ECI];
    sig_en[SIG_T0]       = sel_b_r[SB_T0];
    sig_en[SIG_T1]       = sel_b_r[SB_T1];
  end
  // allocation group
  logic [NPIN-1:0] own_v_r, own_v_nxt;
  logic [SIGW-1:0] own_s_r   [NPIN];
  logic [SIGW-1:0] own_s_nxt [NPIN];
  logic            ovf_r, ovf_nxt;
  always_comb begin
    logic [NPIN-1:0] used;
    logic            found;
    used      = '0;
    found     = 1'b0;
    own_v_nxt = '0;
    ovf_nxt   = 1'b0;
    own_s_nxt = '{default: '0};
    // fixed async serial and radio pins
    // fixed pins are taken whatever their skip bit says
    for (int s = 0; s < NFIX; s++) begin
      if (sig_en[s]) begin
        own_v_nxt[FIXED_PIN[s]] = 1'b1;
        own_s_nxt[FIXED_PIN[s]] = SIGW'(s);
        used[FIXED_PIN[s]]      = 1'b1;
      end
    end
    for (int s = NFIX; s < NSIG; s++) begin
      found = 1'b0;
      if (sig_en[s]) begin
        for (int p = 0; p < NPIN; p++) begin
          if (!found && !used[p] && !skip_r[p]) begin
            found        = 1'b1;
            used[p]      = 1'b1;
            own_v_nxt[p] = 1'b1;
            own_s_nxt[p] = SIGW'(s);
          end
        end
        if (!found) begin
          ovf_nxt = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      own_v_r <= '0;
      ovf_r   <= 1'b0;
      own_s_r <= '{default: '0};
    end else begin
      own_v_r <= own_v_nxt;
      ovf_r   <= ovf_nxt;
      own_s_r <= own_s_nxt;
    end
  end
  // pad group
  logic [NPIN-1:0] pin_val, pin_req, pin_od, oe_n_c, pull_c;
  logic [NPIN-1:0] pad_out_r, pad_oe_n_r, pull_r, pad_drv_r;
  logic [NPIN-1:0] level, edge_c;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_comb begin
        pin_val[g] = own_v_r[g] ? sig_out[own_s_r[g]] : latch_r[g];
        pin_req[g] = own_v_r[g] ? sig_oe[own_s_r[g]] : 1'b1;
        pin_od[g]  = own_v_r[g] &&
                     (own_s_r[g] == SIG_SDA || own_s_r[g] == SIG_SCL);
      end
      pcpa_pad_ctl u_pad (
        .xbar_en   (xbar_en_r),
        .digital   (inmode_r[g]),
        .push_pull (outmode_r[g]),
        .force_od  (pin_od[g]),
        .drv_req   (pin_req[g]),
        .drv_val   (pin_val[g]),
        .oe_n      (oe_n_c[g]),
        .pullup_en (pull_c[g])
      );
      pcpa_sync u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pad_in  (pad_in[g]),
        .level_r (level[g]),
        .edge_r  (edge_c[g])
      );
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (rst) begin
      {pad_out_r, pad_oe_n_r, pull_r} <= '1;
      pad_drv_r  <= '0;
    end else begin
      pad_out_r  <= pin_val;
      pad_oe_n_r <= oe_n_c;
      pull_r     <= pull_c;
      pad_drv_r  <= drv_r;
    end
  end
  // input and event group
  logic [NPIN-1:0] rd_c, rd_r, edge_r;
  logic [NSIG-1:0] sig_in_nxt, sig_in_r;
  logic            irq0_nxt, irq1_nxt, match_nxt;
  logic            irq0_r, irq1_r, match_r;
  logic [2:0]      sel0, sel1;
  always_comb begin
    rd_c = level & inmode_r;
    // unrouted peripheral inputs idle high
    sig_in_nxt = '1;
    for (int p = 0; p < NPIN; p++) begin
      if (own_v_r[p]) begin
        sig_in_nxt[own_s_r[p]] = rd_c[p];
      end
    end
    sel0 = ext_irq_pin_config[EIC_SEL0_LSB +: 3];
    sel1 = ext_irq_pin_config[EIC_SEL1_LSB +: 3];
    irq0_nxt  = inmode_r[sel0] &
                (rd_c[sel0] == ext_irq_pin_config[EIC_POL0]);
    irq1_nxt  = inmode_r[sel1] &
                (rd_c[sel1] == ext_irq_pin_config[EIC_POL1]);
    match_nxt = |((rd_c[7:0] ^ port_a_match_value) &
                  port_a_match_mask & inmode_r[7:0]);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_r     <= '0;
      edge_r   <= '0;
      sig_in_r <= '1;
      {irq0_r, irq1_r, match_r} <= 3'b000;
    end else begin
      rd_r     <= rd_c;
      edge_r   <= edge_c & inmode_r;
      sig_in_r <= sig_in_nxt;
      {irq0_r, irq1_r, match_r} <= {irq0_nxt, irq1_nxt, match_nxt};
    end
  end
  assign pad_out        = pad_out_r;
  assign pad_oe_n       = pad_oe_n_r;
  assign pad_pullup_en  = pull_r;
  assign pad_drive_high = pad_drv_r;
  assign port_read      = rd_r;
  assign sig_in         = sig_in_r;
  assign pin_edge       = edge_r;
  assign ext_irq0       = irq0_r;
  assign ext_irq1       = irq1_r;
  assign port_match     = match_r;
  assign alloc_overflow = ovf_r;
  // checking helpers
  logic [NPIN-1:0] flex_own;
  logic            nss_placed;
  always_comb begin
    nss_placed = 1'b0;
    for (int p = 0; p < NPIN; p++) begin
      flex_own[p] = own_v_r[p] && (own_s_r[p] >= SIGW'(NFIX));
      nss_placed |= own_v_r[p] && own_s_r[p] == SIG_GEN_NSS;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_skip_not_taken: assert property (
    (flex_own & $past(skip_r)) == '0)
    else $error("skipped pin claimed by crossbar");
  a_uart_fixed: assert property (
    $past(sel_a_r[SA_UART]) |-> own_v_r[5'h04] && own_v_r[5'h05] &&
      own_s_r[5'h04] == SIG_UART_TX && own_s_r[5'h05] == SIG_UART_RX)
    else $error("async serial not on fixed pins");
  a_radio_nss: assert property (
    $past(sel_b_r[SB_RADIO]) |-> $past(rad_four_r) ==
      (own_v_r[5'h0B] && own_s_r[5'h0B] == SIG_RAD_NSS))
    else $error("radio fourth pin wrong for mode");
  a_first_flex: assert property (
    $past(sel_a_r[SA_GEN] && skip_r[1:0] == 2'b00) |->
      own_s_r[0] == SIG_GEN_SCK && own_s_r[1] == SIG_GEN_MISO)
    else $error("first free pins not given in order");
  a_xbar_off: assert property (
    !$past(xbar_en_r) |-> pad_oe_n == '1)
    else $error("driver on while crossbar disabled");
  a_smb_od: assert property (
    ($past(pin_od) & pad_out_r & ~pad_oe_n_r) == '0)
    else $error("two-wire pin driven high");
  a_nss_mode: assert property (
    $past(sel_a_r[SA_GEN] && !gen_four_r) |-> !nss_placed)
    else $error("slave-select placed in three-wire mode");
  a_osc_skip: assert property (
    $past(skip_r[7:0] == 8'h0C) |-> !flex_own[2] && !flex_own[3])
    else $error("oscillator pins allocated");
  a_analog_edge: assert property (
    (pin_edge & ~$past(inmode_r)) == '0)
    else $error("edge reported on analog pin");
  a_reset_pads: assert property (
    $past(rst) |-> pad_oe_n == '1 && pad_pullup_en == '1 &&
                   pad_drive_high == '0)
    else $error("pads not at reset default");
  c_uart_placed: cover property (own_v_r[5'h04] && xbar_en_r);
  c_gen_four:    cover property (nss_placed);
  c_pin_edge:    cover property (|pin_edge);
  c_overflow:    cover property (alloc_overflow);
endmodule : pcpa_crossbar

// ---- design/pcpa_pkg.sv ----
package pcpa_pkg;
  // pins P0.0..P2.6 as port*8+bit, P2.7 is not routed here
  localparam int NPIN = 23;
  localparam int NSIG = 26;
  localparam int NFIX = 6;
  localparam int SIGW = 5;
  localparam int PCA_MAX = 6;

  // signal indices in fixed priority order
  localparam logic [4:0] SIG_UART_TX  = 5'h00;
  localparam logic [4:0] SIG_UART_RX  = 5'h01;
  localparam logic [4:0] SIG_RAD_SCK  = 5'h02;
  localparam logic [4:0] SIG_RAD_MISO = 5'h03;
  localparam logic [4:0] SIG_RAD_MOSI = 5'h04;
  localparam logic [4:0] SIG_RAD_NSS  = 5'h05;
  localparam logic [4:0] SIG_GEN_SCK  = 5'h06;
  localparam logic [4:0] SIG_GEN_MISO = 5'h07;
  localparam logic [4:0] SIG_GEN_MOSI = 5'h08;
  localparam logic [4:0] SIG_GEN_NSS  = 5'h09;
  localparam logic [4:0] SIG_SDA      = 5'h0A;
  localparam logic [4:0] SIG_SCL      = 5'h0B;
  localparam logic [4:0] SIG_CP0      = 5'h0C;
  localparam logic [4:0] SIG_CP0A     = 5'h0D;
  localparam logic [4:0] SIG_CP1      = 5'h0E;
  localparam logic [4:0] SIG_CP1A     = 5'h0F;
  localparam logic [4:0] SIG_SYSCK    = 5'h10;
  localparam logic [4:0] SIG_CEX0     = 5'h11;
  localparam logic [4:0] SIG_ECI      = 5'h17;
  localparam logic [4:0] SIG_T0       = 5'h18;
  localparam logic [4:0] SIG_T1       = 5'h19;

  // fixed pins of the top two functions, indexed by signal
  localparam logic [4:0] FIXED_PIN [0:NFIX-1] =
    '{5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B};

  // crossbar_select_a bit positions
  localparam int SA_UART  = 0;
  localparam int SA_GEN   = 1;
  localparam int SA_SMB   = 2;
  localparam int SA_SYSCK = 3;
  localparam int SA_CP0   = 4;
  localparam int SA_CP0A  = 5;
  localparam int SA_CP1   = 6;
  localparam int SA_CP1A  = 7;
  // crossbar_select_b bit positions
  localparam int SB_PCA_LSB = 0;
  localparam int SB_ECI     = 3;
  localparam int SB_T0      = 4;
  localparam int SB_T1      = 5;
  localparam int SB_RADIO   = 6;
  // crossbar_select_c bit position
  localparam int SC_XBAR_EN = 6;
  // slave_select_mode_field bit that selects four-wire
  localparam int SSM_FOUR = 1;
  // ext_irq_pin_config layout
  localparam int EIC_SEL0_LSB = 0;
  localparam int EIC_POL0     = 3;
  localparam int EIC_SEL1_LSB = 4;
  localparam int EIC_POL1     = 7;

  // reset values
  localparam logic [7:0]  SKIP_RST   = 8'h00;
  localparam logic [23:0] INMODE_RST = 24'hFFFFFF;
  localparam logic [23:0] OUTMODE_RST = 24'h000000;
  localparam logic [23:0] DRV_RST    = 24'h000000;
  localparam logic [23:0] LATCH_RST  = 24'hFFFFFF;
endpackage : pcpa_pkg

// ---- design/pcpa_sync.sv ----
`timescale 1ns/1ps
module pcpa_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pad_in,
  output logic      level_r,
  output logic      edge_r
);
  logic s1_r, s2_r, s3_r;
  logic level_nxt, edge_nxt;

  // a change counts once the second and third stage agree
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    edge_nxt  = level_nxt != level_r;
  end

  // idle value high matches the weak pull-up
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
      edge_r  <= 1'b0;
    end else begin
      s1_r    <= pad_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
      edge_r  <= edge_nxt;
    end
  end
endmodule : pcpa_sync

// ---- design/pcpa_pad_ctl.sv ----
`timescale 1ns/1ps
module pcpa_pad_ctl (
  input  wire logic xbar_en,
  input  wire logic digital,
  input  wire logic push_pull,
  input  wire logic force_od,
  input  wire logic drv_req,
  input  wire logic drv_val,
  output logic      oe_n,
  output logic      pullup_en
);
  logic drive;

  always_comb begin
    // open-drain only ever pulls low; forced od wins over push-pull
    drive     = xbar_en & digital & drv_req &
                ((push_pull & ~force_od) | ~drv_val);
    oe_n      = ~drive;
    // pull-up off when pulling low, and off for analog pins
    pullup_en = digital & ~(drive & ~drv_val);
  end
endmodule : pcpa_pad_ctl

// ---- bench/pcpa_pad_model.sv ----
`timescale 1ns/1ps
module pcpa_pad_model (
  input  wire logic                      mclk,
  input  wire logic [pcpa_pkg::NPIN-1:0] pad_out,
  input  wire logic [pcpa_pkg::NPIN-1:0] pad_oe_n,
  input  wire logic [pcpa_pkg::NPIN-1:0] pad_pullup_en,
  input  wire logic [pcpa_pkg::NPIN-1:0] ext_en,
  input  wire logic [pcpa_pkg::NPIN-1:0] ext_val,
  output logic [pcpa_pkg::NPIN-1:0]      pad_in
);
  import pcpa_pkg::*;
  logic [NPIN-1:0] float_r = 23'h555555;
  // a pad nobody holds must not settle on a convenient value
  always @(posedge mclk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe_n[i] === 1'b0) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i] === 1'b1) pad_in[i] = 1'b1;
      else pad_in[i] = float_r[i];
    end
  end
endmodule : pcpa_pad_model

// ---- bench/pcpa_crossbar_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module pcpa_crossbar_test;
  import pcpa_pkg::*;
  logic            mclk = 0;
  logic            rst = 1;
  logic [7:0]      sel_a = 0, sel_b = 0, sel_c = 0, eic = 0, pmm = 0, pmv = 0;
  logic [7:0]      skip0 = 0, skip1 = 0, skip2 = 0;
  logic [23:0]     omode = 0, imode = '1, drv = 0, latch = '1;
  logic [1:0]      ssm = 0;
  logic            rad4 = 0;
  logic [NSIG-1:0] sig_out = 26'h1B2D4E9, sig_oe = '1, sig_in;
  logic [NPIN-1:0] pad_in, pad_out, pad_oe_n, pad_pu, pad_dh;
  logic [NPIN-1:0] port_read, pin_edge, ext_en = 0, ext_val = 0;
  logic            irq0, irq1, pmatch, ovf;
  int              failures = 0;
  int              total_checks = 0;
  int              ecnt [3];
  logic [47:0]     tbl [6];

  always #12.5 mclk = ~mclk;

  pcpa_crossbar u_pcpa_crossbar (.mclk(mclk), .rst(rst),
    .crossbar_select_a(sel_a), .crossbar_select_b(sel_b),
    .crossbar_select_c(sel_c), .pin_skip_mask_p0(skip0),
    .pin_skip_mask_p1(skip1), .pin_skip_mask_p2(skip2),
    .output_mode_select(omode), .input_mode_select(imode),
    .drive_strength_select(drv), .port_latch(latch),
    .slave_select_mode_field(ssm), .radio_link_four_wire(rad4),
    .sig_out(sig_out), .sig_oe(sig_oe), .ext_irq_pin_config(eic),
    .port_a_match_mask(pmm), .port_a_match_value(pmv), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pu),
    .pad_drive_high(pad_dh), .port_read(port_read), .sig_in(sig_in),
    .pin_edge(pin_edge), .ext_irq0(irq0), .ext_irq1(irq1),
    .port_match(pmatch), .alloc_overflow(ovf));

  pcpa_pad_model u_pcpa_pad_model (.mclk(mclk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pu), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  function automatic logic want(input int s);
    int n;
    n = (sel_b[2:0] > 6) ? 6 : int'(sel_b[2:0]);
    case (s)
      6, 7, 8: return sel_a[SA_GEN];
      9:       return sel_a[SA_GEN] & ssm[SSM_FOUR];
      10, 11:  return sel_a[SA_SMB];
      12:      return sel_a[SA_CP0];
      13:      return sel_a[SA_CP0A];
      14:      return sel_a[SA_CP1];
      15:      return sel_a[SA_CP1A];
      16:      return sel_a[SA_SYSCK];
      23:      return sel_b[SB_ECI];
      24:      return sel_b[SB_T0];
      25:      return sel_b[SB_T1];
      default: return (s - 17) < n;
    endcase
  endfunction : want

  task automatic check_map();
    int              own [NPIN];
    int              p;
    logic            ovx, pp;
    logic [NPIN-1:0] used, skp, msk, eo, eoe;
    used = '0;
    ovx = 1'b0;
    skp = {skip2[6:0], skip1, skip0};
    for (int i = 0; i < NPIN; i++) own[i] = -1;
    // fixed functions land on their pins regardless of skip bits
    for (int s = 0; s < NFIX; s++) begin
      if ((s < 2 && sel_a[SA_UART]) ||
          (s >= 2 && sel_b[SB_RADIO] && (s < 5 || rad4))) begin
        own[FIXED_PIN[s]] = s;
        used[FIXED_PIN[s]] = 1'b1;
      end
    end
    for (int s = NFIX; s < NSIG; s++) begin
      if (want(s)) begin
        p = 0;
        while (p < NPIN && (used[p] || skp[p])) p++;
        if (p == NPIN) ovx = 1'b1;
        else begin
          own[p] = s;
          used[p] = 1'b1;
        end
      end
    end
    for (int i = 0; i < NPIN; i++) begin
      msk[i] = own[i] >= 0;
      eo[i] = msk[i] ? sig_out[own[i]] : latch[i];
      // two-wire pins drive only low whatever the mode
      pp = omode[i] && !(own[i] == 10 || own[i] == 11);
      eoe[i] = !(pp || !eo[i]);
    end
    `CHK("pad_out", eo, pad_out)
    `CHK("pad_oe_n", eoe, pad_oe_n)
    `CHK("alloc_overflow", ovx, ovf)
  endtask : check_map

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_sim();
  end

  initial begin
    // sel_a, sel_b, skip0, skip1, ssm, four-wire radio
    tbl[0] = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    tbl[1] = {8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h01};
    tbl[2] = {8'h07, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00};
    tbl[3] = {8'h07, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h00};
    tbl[4] = {8'hFF, 8'h5E, 8'h00, 8'h00, 8'h02, 8'h01};
    tbl[5] = {8'h71, 8'h47, 8'hFF, 8'h0F, 8'h00, 8'h00};
    repeat (4) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    `CHK("oe_rst", {NPIN{1'b1}}, pad_oe_n)
    `CHK("pu_rst", {NPIN{1'b1}}, pad_pu)
    `CHK("drv_rst", {NPIN{1'b0}}, pad_dh)
    // drivers would be on here if the enable were ignored
    sel_a = 8'hFF;
    omode = '1;
    latch = '0;
    repeat (4) @(negedge mclk);
    `CHK("oe_off", {NPIN{1'b1}}, pad_oe_n)
    sel_c = 8'h40;
    omode = 24'h00FF0F;
    latch = 24'hC3A5F0;
    for (int k = 0; k < 6; k++) begin
      {sel_a, sel_b, skip0, skip1} = tbl[k][47:16];
      ssm = tbl[k][9:8];
      rad4 = tbl[k][0];
      repeat (4) @(negedge mclk);
      check_map();
    end
    drv = 24'h5A5A5A;
    repeat (3) @(negedge mclk);
    `CHK("drive", drv[NPIN-1:0], pad_dh)
    // analog reserve: open-drain, latch high, skipped
    imode = 24'hFFFFFE;
    // general purpose pins kept out of the crossbar
    {sel_a, sel_b, skip0, skip1, ssm} = {8'h01, 8'h00, 8'h03, 8'h00, 2'b0};
    omode = '0;
    latch = '1;
    sig_oe = '0;
    eic = 8'h01;
    pmm = 8'h02;
    pmv = 8'h02;
    ext_en = 23'h000023;
    ext_val = 23'h000023;
    repeat (8) @(negedge mclk);
    `CHK("read_an", 1'b0, port_read[0])
    `CHK("read_dig", 1'b1, port_read[1])
    `CHK("pu_an", 1'b0, pad_pu[0])
    `CHK("irq0_idle", 1'b0, irq0)
    ext_val = '0;
    ecnt = '{0, 0, 0};
    repeat (8) begin
      @(negedge mclk);
      ecnt[0] += pin_edge[0];
      ecnt[1] += pin_edge[1];
      ecnt[2] += pin_edge[5];
    end
    `CHK("edge_an", 0, ecnt[0])
    `CHK("edge_gpio", 1, ecnt[1])
    `CHK("edge_xbar", 1, ecnt[2])
    `CHK("urx_in", 1'b0, sig_in[1])
    `CHK("irq0", 1'b1, irq0)
    `CHK("irq1_an", 1'b0, irq1)
    `CHK("match", 1'b1, pmatch)
    end_sim();
  end
endmodule : pcpa_crossbar_test
